/* logic/bta_pkg.sv */
`default_nettype none
package bta_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  ADDR_PIVOT    = 8'h00;
  localparam logic [7:0]  ADDR_MODE     = 8'h04;
  localparam logic [7:0]  ADDR_PAGE     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
  localparam int          REV_EN_BIT    = 15;
  localparam int          SEL_LSB       = 8;
  localparam int          PAGE_CFG_BIT  = 7;
  localparam logic [3:0]  SEL_NONE      = 4'hF;
  localparam logic [15:0] PIVOT_RST     = 16'h0000;
  localparam logic [15:0] MODE_RST      = 16'h0F00;
  localparam logic [7:0]  PAGE_RST      = 8'h00;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    AM_DIRECT, AM_INDIRECT, AM_POST_INC, AM_PRE_INC,
    AM_POST_DEC, AM_PRE_DEC, AM_OTHER
  } bta_amode_type;

  typedef struct packed {
    logic          valid;
    logic          write;
    logic          byte_op;
    bta_amode_type amode;
    logic [3:0]    ptr_idx;
    logic [15:0]   ptr;
    logic [15:0]   offset;
    logic          mod_active;
    logic [15:0]   mod_addr;
  } bta_agu_req_type;

  typedef struct packed {
    logic        valid;
    logic        bitrev;
    logic [15:0] ea;
    logic [15:0] ptr_new;
  } bta_agu_rsp_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        high;
    logic        byte_op;
    logic        psv;
    logic [15:0] ea;
    logic [15:0] wdata;
  } bta_tbl_req_type;

  typedef struct packed {
    logic        valid;
    logic        refused;
    logic [15:0] data;
  } bta_tbl_rsp_type;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        cfg_space;
    logic [23:0] addr;
    logic [23:0] wdata;
    logic [2:0]  wstrb;
  } bta_prog_type;

  typedef struct packed {
    logic            ph;
    logic            wr;
    logic [7:0]      addr;
    logic            hreadyout;
    logic [31:0]     hrdata;
    logic [15:0]     pivot;
    logic [15:0]     mode;
    logic [7:0]      page;
    logic            last_rev;
    logic            pend;
    logic            pend_high;
    logic            pend_byte;
    logic            pend_bsel;
    logic            tbl_ready;
    bta_agu_rsp_type address_generator;
    bta_tbl_rsp_type tbl;
    bta_prog_type    prog;
  } bta_state_type;

endpackage
`default_nettype wire

/* logic/bta_addr_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R01 - reversal only on X write data writes
// R02 - active: select not 1111, enable, pre/post-inc
// R03 - pivot control: enable bit15, pivot bits14:0
// R04 - modifier reversed, pointer kept normal order
// R05 - reversal adds pivot, ignores mode offset
// R06 - word data: lsb clear, pivot scaled
// R07 - byte writes, other modes: normal addresses
// R08 - reversal beats modulo on data writes
// R09 - no reversed-pointer read right after pivot write
// R10 - reversed buffer start aligned to its size
// R11 - program address is page over effective address
// R12 - page bit7 picks config space, reads allowed
// R13 - program address steps two per word
// R14 - low read: word, or selected byte low
// R15 - high word read: bits 23:16, upper zero
// R16 - high byte read: phantom byte reads zero
// R17 - table operations accept any alignment
// R18 - program window read-only, low word only
module bta_addr_gen (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire bta_pkg::bta_agu_req_type agu_req,
  output bta_pkg::bta_agu_rsp_type      agu_rsp,
  input  wire bta_pkg::bta_tbl_req_type tbl_req,
  output logic                          tbl_ready,
  output bta_pkg::bta_tbl_rsp_type      tbl_rsp,
  output bta_pkg::bta_prog_type         prog,
  input  wire logic                     prog_rvalid,
  input  wire logic [23:0]              prog_rdata
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction

  bta_pkg::bta_state_type s_r;
  bta_pkg::bta_state_type s_nxt;

  logic        rev_en;
  logic [3:0]  rev_sel;
  logic [15:0] pivot_bytes;
  logic [15:0] rev_sum;
  logic        is_inc;
  logic        rev_act;
  logic [15:0] norm_new;
  logic        bsel;

  always_comb begin
    rev_en      = s_r.pivot[bta_pkg::REV_EN_BIT];                          // [R03]
    rev_sel     = s_r.mode[bta_pkg::SEL_LSB +: 4];
    pivot_bytes = {s_r.pivot[14:0], 1'b0};                                 // [R03] [R06]
    // reverse-carry add: carries run toward lsb, so aligned buffers wrap [R10]
    rev_sum     = rev16(16'(rev16(agu_req.ptr) + rev16(pivot_bytes)));  // [R04] [R05]
    is_inc      = (agu_req.amode == bta_pkg::AM_PRE_INC) ||
                  (agu_req.amode == bta_pkg::AM_POST_INC);
    rev_act     = (rev_sel != bta_pkg::SEL_NONE) && rev_en && is_inc &&    // [R02]
                  (agu_req.ptr_idx == rev_sel) &&
                  agu_req.write && !agu_req.byte_op;                       // [R01] [R07]
    norm_new    = agu_req.mod_active ? agu_req.mod_addr :
                  16'(agu_req.ptr + agu_req.offset);
    bsel        = tbl_req.ea[0];
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    // ahb slave: one wait cycle per transfer, read data latched then
    if (hsel && htrans == bta_pkg::HTRANS_NONSEQ && hready) begin
      s_nxt.ph        = 1'b1;
      s_nxt.wr        = hwrite;
      s_nxt.addr      = haddr[7:0];
      s_nxt.hreadyout = 1'b0;
    end else if (s_r.ph) begin
      s_nxt.ph        = 1'b0;
      s_nxt.hreadyout = 1'b1;
      s_nxt.hrdata    = '0;
      if (s_r.wr) begin
        unique case (s_r.addr)
          bta_pkg::ADDR_PIVOT: s_nxt.pivot = hwdata[15:0];
          bta_pkg::ADDR_MODE:  s_nxt.mode  = hwdata[15:0];
          bta_pkg::ADDR_PAGE:  s_nxt.page  = hwdata[7:0];
          default:             s_nxt.pivot = s_r.pivot;
        endcase
      end else begin
        unique case (s_r.addr)
          bta_pkg::ADDR_PIVOT:  s_nxt.hrdata = {16'h0000, s_r.pivot};
          bta_pkg::ADDR_MODE:   s_nxt.hrdata = {16'h0000, s_r.mode};
          bta_pkg::ADDR_PAGE:   s_nxt.hrdata = {24'h000000, s_r.page};
          bta_pkg::ADDR_STATUS: s_nxt.hrdata = {30'h0, s_r.pend, s_r.last_rev};
          default:              s_nxt.hrdata = '0;
        endcase
      end
    end

    // ****************************************
    // x address unit, reads and writes
    // ****************************************
    s_nxt.address_generator.valid  = agu_req.valid;
    s_nxt.address_generator.bitrev = agu_req.valid && rev_act;
    if (agu_req.valid) begin
      if (rev_act) begin
        // reversal wins even when modulo is on for this pointer [R08]
        s_nxt.address_generator.ptr_new = {rev_sum[15:1], 1'b0};                         // [R05] [R06]
        s_nxt.address_generator.ea      = (agu_req.amode == bta_pkg::AM_PRE_INC) ?
                            {rev_sum[15:1], 1'b0} : {agu_req.ptr[15:1], 1'b0};
        s_nxt.last_rev    = 1'b1;
      end else begin
        // normal path for reads, byte writes and other modes [R07]
        unique case (agu_req.amode)
          bta_pkg::AM_PRE_INC, bta_pkg::AM_PRE_DEC: begin
            s_nxt.address_generator.ea      = norm_new;
            s_nxt.address_generator.ptr_new = norm_new;
          end
          bta_pkg::AM_POST_INC, bta_pkg::AM_POST_DEC: begin
            s_nxt.address_generator.ea      = agu_req.ptr;
            s_nxt.address_generator.ptr_new = norm_new;
          end
          default: begin
            s_nxt.address_generator.ea      = agu_req.mod_active ? agu_req.mod_addr :
                                16'(agu_req.ptr + agu_req.offset);
            s_nxt.address_generator.ptr_new = agu_req.ptr;
          end
        endcase
        s_nxt.last_rev = 1'b0;
      end
    end

    // ****************************************
    // table and program window access
    // ****************************************
    s_nxt.prog.req   = 1'b0;
    s_nxt.prog.write = 1'b0;
    s_nxt.prog.wstrb = 3'h0;
    s_nxt.tbl.valid   = 1'b0;
    s_nxt.tbl.refused = 1'b0;
    if (tbl_req.valid && s_r.tbl_ready) begin
      s_nxt.prog.addr      = {s_r.page, tbl_req.ea};                       // [R11] [R13] [R17]
      s_nxt.prog.cfg_space = s_r.page[bta_pkg::PAGE_CFG_BIT];              // [R12]
      if (tbl_req.psv && tbl_req.write) begin
        s_nxt.tbl.refused = 1'b1;                                          // [R18]
      end else if (tbl_req.write) begin
        s_nxt.prog.req   = 1'b1;
        s_nxt.prog.write = 1'b1;
        if (tbl_req.high) begin
          s_nxt.prog.wdata = {tbl_req.wdata[7:0], 16'h0000};
          s_nxt.prog.wstrb = (tbl_req.byte_op && bsel) ? 3'h0 : 3'h4;
        end else if (tbl_req.byte_op) begin
          s_nxt.prog.wdata = {8'h00, tbl_req.wdata[7:0], tbl_req.wdata[7:0]};
          s_nxt.prog.wstrb = bsel ? 3'h2 : 3'h1;
        end else begin
          s_nxt.prog.wdata = {8'h00, tbl_req.wdata};
          s_nxt.prog.wstrb = 3'h3;
        end
      end else begin
        s_nxt.prog.req  = 1'b1;
        s_nxt.pend      = 1'b1;
        s_nxt.pend_high = tbl_req.high && !tbl_req.psv;                    // [R18]
        s_nxt.pend_byte = tbl_req.byte_op && !tbl_req.psv;
        s_nxt.pend_bsel = bsel;
      end
    end
    if (s_r.pend && prog_rvalid) begin
      s_nxt.pend      = 1'b0;
      s_nxt.tbl.valid = 1'b1;
      if (s_r.pend_high) begin
        s_nxt.tbl.data = (s_r.pend_byte && s_r.pend_bsel) ? 16'h0000 :   // [R16]
                         {8'h00, prog_rdata[23:16]};                       // [R15]
      end else if (s_r.pend_byte) begin
        s_nxt.tbl.data = s_r.pend_bsel ? {8'h00, prog_rdata[15:8]} :      // [R14]
                         {8'h00, prog_rdata[7:0]};
      end else begin
        s_nxt.tbl.data = prog_rdata[15:0];                                 // [R14]
      end
    end
    s_nxt.tbl_ready = !s_nxt.pend;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r           <= '0;
      s_r.hreadyout <= 1'b1;
      s_r.tbl_ready <= 1'b1;
      s_r.pivot     <= bta_pkg::PIVOT_RST;
      s_r.mode      <= bta_pkg::MODE_RST;
      s_r.page      <= bta_pkg::PAGE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hrdata    = s_r.hrdata;
  assign hreadyout = s_r.hreadyout;
  assign hresp     = 1'b0;
  assign agu_rsp   = s_r.address_generator;
  assign tbl_ready = s_r.tbl_ready;
  assign tbl_rsp   = s_r.tbl;
  assign prog      = s_r.prog;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_REV_WRITE_ONLY: assert property ( // [R01]
    agu_rsp.bitrev |-> $past(agu_req.write && !agu_req.byte_op))
    else $error("reversed address on a read or byte write");
  AST_REV_COND: assert property ( // [R02]
    agu_rsp.bitrev |-> $past(rev_sel != bta_pkg::SEL_NONE && rev_en && is_inc))
    else $error("reversal without its three conditions");
  AST_REV_LSB: assert property ( // [R06]
    agu_rsp.bitrev |-> (agu_rsp.ea[0] == 1'b0 && agu_rsp.ptr_new[0] == 1'b0))
    else $error("reversed address lsb not clear");
  AST_REV_PRE_EA: assert property ( // [R05]
    agu_rsp.bitrev && $past(agu_req.amode == bta_pkg::AM_PRE_INC)
    |-> agu_rsp.ea == agu_rsp.ptr_new)
    else $error("pre-increment reversed address differs from pointer");
  AST_REV_OVER_MOD: assert property ( // [R08]
    agu_req.valid && agu_req.mod_active && rev_act |=> agu_rsp.bitrev)
    else $error("modulo overrode reversal");
  AST_BYTE_NORMAL: assert property ( // [R07]
    agu_req.valid && agu_req.byte_op |=> !agu_rsp.bitrev)
    else $error("byte access used reversal");
  AST_PAGE_ADDR: assert property ( // [R11]
    tbl_req.valid && tbl_ready && !tbl_req.psv
    |=> prog.addr == {$past(s_r.page), $past(tbl_req.ea)})
    else $error("program address not page over ea");
  AST_HIGH_ZERO: assert property ( // [R15]
    tbl_rsp.valid && $past(s_r.pend_high) |-> tbl_rsp.data[15:8] == 8'h00)
    else $error("high table read upper byte not zero");
  AST_PSV_RO: assert property ( // [R18]
    tbl_req.valid && tbl_ready && tbl_req.psv && tbl_req.write
    |=> !prog.req && tbl_rsp.refused)
    else $error("program window write not refused");
  AST_AHB_WAIT: assert property (
    hsel && htrans == bta_pkg::HTRANS_NONSEQ && hready |=> !hreadyout ##1 hreadyout)
    else $error("ahb transfer timing wrong");
  AST_REV_POST_EA: assert property ( // [R04]
    agu_rsp.bitrev && $past(agu_req.amode == bta_pkg::AM_POST_INC)
    |-> agu_rsp.ea == {$past(agu_req.ptr[15:1]), 1'b0})
    else $error("post-increment reversed address not old pointer");
  AST_NORM_PRE: assert property ( // [R07]
    agu_req.valid && !rev_act && agu_req.amode == bta_pkg::AM_PRE_INC
    |=> agu_rsp.ea == agu_rsp.ptr_new)
    else $error("normal pre-increment address differs from pointer");
  AST_NORM_POST: assert property ( // [R07]
    agu_req.valid && !rev_act && agu_req.amode == bta_pkg::AM_POST_INC
    |=> agu_rsp.ea == $past(agu_req.ptr))
    else $error("normal post-increment address not old pointer");
  AST_NO_REV_READ: assert property ( // [R01]
    agu_req.valid && !agu_req.write |=> !agu_rsp.bitrev)
    else $error("read used reversal");
  AST_NO_REV_MODE: assert property ( // [R02]
    agu_req.valid && !is_inc |=> !agu_rsp.bitrev)
    else $error("reversal outside pre or post increment");
  AST_NO_REV_SEL: assert property ( // [R02]
    agu_req.valid && rev_sel == bta_pkg::SEL_NONE |=> !agu_rsp.bitrev)
    else $error("reversal with no pointer selected");
  AST_NO_REV_OFF: assert property ( // [R03]
    agu_req.valid && !rev_en |=> !agu_rsp.bitrev)
    else $error("reversal while enable bit clear");
  AST_AGU_ANSWER: assert property (
    agu_req.valid |=> agu_rsp.valid)
    else $error("address request not answered next cycle");

  // ****************************************
  // table checks
  // ****************************************
  AST_CFG_SPACE: assert property ( // [R12]
    prog.req |-> prog.cfg_space == prog.addr[23])
    else $error("space select differs from page top bit");
  AST_TBL_TAKE: assert property ( // [R11]
    tbl_req.valid && tbl_ready && !tbl_req.write
    |=> prog.req && !prog.write && !tbl_ready)
    else $error("table read not issued");
  AST_TBL_WRITE_REQ: assert property ( // [R11]
    tbl_req.valid && tbl_ready && tbl_req.write && !tbl_req.psv
    |=> prog.req && prog.write)
    else $error("table write not issued");
  AST_STRB_LOW_WORD: assert property ( // [R14]
    tbl_req.valid && tbl_ready && tbl_req.write && !tbl_req.psv && !tbl_req.high &&
    !tbl_req.byte_op |=> prog.wstrb == 3'h3)
    else $error("low word write strobes wrong");
  AST_STRB_HIGH: assert property ( // [R15]
    tbl_req.valid && tbl_ready && tbl_req.write && !tbl_req.psv && tbl_req.high &&
    !(tbl_req.byte_op && tbl_req.ea[0]) |=> prog.wstrb == 3'h4)
    else $error("high word write strobe wrong");
  AST_LOW_WORD: assert property ( // [R14]
    tbl_rsp.valid && $past(!s_r.pend_high && !s_r.pend_byte)
    |-> tbl_rsp.data == $past(prog_rdata[15:0]))
    else $error("low word read data wrong");
  AST_BYTE_LANE: assert property ( // [R14]
    tbl_rsp.valid && $past(!s_r.pend_high && s_r.pend_byte)
    |-> tbl_rsp.data == {8'h00, ($past(s_r.pend_bsel) ? $past(prog_rdata[15:8]) :
                                                        $past(prog_rdata[7:0]))})
    else $error("low byte read lane wrong");
  AST_HIGH_WORD: assert property ( // [R15]
    tbl_rsp.valid && $past(s_r.pend_high && !(s_r.pend_byte && s_r.pend_bsel))
    |-> tbl_rsp.data == {8'h00, $past(prog_rdata[23:16])})
    else $error("high read data wrong");
  AST_HIGH_PHANTOM: assert property ( // [R16]
    tbl_rsp.valid && $past(s_r.pend_high && s_r.pend_byte && s_r.pend_bsel)
    |-> tbl_rsp.data == 16'h0000)
    else $error("phantom byte read not zero");
  AST_PSV_LOW: assert property ( // [R18]
    tbl_req.valid && tbl_ready && tbl_req.psv && !tbl_req.write
    |=> !s_r.pend_high && !s_r.pend_byte)
    else $error("program window read not forced to low word");

  // ****************************************
  // scenario covers
  // ****************************************
  COV_REV: cover property (agu_rsp.bitrev);
  COV_HIGH_BYTE: cover property (tbl_rsp.valid && s_r.pend_high && s_r.pend_byte);
  COV_REV_MOD: cover property (agu_rsp.bitrev && $past(agu_req.mod_active));
  COV_PSV_REF: cover property (tbl_rsp.refused);
  COV_AHB_RD: cover property (s_r.ph && !s_r.wr ##1 hreadyout);

endmodule
`default_nettype wire

/* testbench/bta_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// program memory array stand-in
// ****************************************
module bta_prog_mem (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire bta_pkg::bta_prog_type prog,
  input  wire logic [2:0]            lat,
  output logic                       prog_rvalid,
  output logic [23:0]                prog_rdata
);
  logic [2:0]  cnt;
  logic [23:0] addr_q;
  // contents follow the address so the bench predicts them without a copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt         <= 3'h0;
      addr_q      <= 24'h000000;
      prog_rvalid <= 1'b0;
      prog_rdata  <= 24'h5A5A5A;
    end else begin
      prog_rvalid <= 1'b0;
      prog_rdata  <= ~prog_rdata;  // released bus flips every cycle, showing the last word inverted, then as it was
      if (prog.req && !prog.write) begin
        addr_q <= prog.addr;
        cnt    <= lat;
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end
      if (cnt == 3'h1) begin
        prog_rvalid <= 1'b1;
        prog_rdata  <= {addr_q[7:0] ^ addr_q[23:16], addr_q[15:0] ^ 16'hC3A5};
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/bta_addr_gen_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module bta_addr_gen_bench;
  logic                     hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]              haddr, hwdata, hrdata, rd;
  logic [1:0]               htrans;
  logic [2:0]               hsize, lat;
  bta_pkg::bta_agu_req_type agu_req;
  bta_pkg::bta_agu_rsp_type agu_rsp;
  bta_pkg::bta_tbl_req_type tbl_req;
  bta_pkg::bta_tbl_rsp_type tbl_rsp;
  bta_pkg::bta_prog_type    prog;
  logic                     tbl_ready, prog_rvalid, br;
  logic [23:0]              prog_rdata;
  logic [15:0]              p, ea, pn;
  logic [7:0]               page;
  bta_pkg::bta_amode_type   m;
  int                       num_errors, checked, k;

  bta_addr_gen i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .agu_req(agu_req),
    .agu_rsp(agu_rsp), .tbl_req(tbl_req), .tbl_ready(tbl_ready), .tbl_rsp(tbl_rsp),
    .prog(prog), .prog_rvalid(prog_rvalid), .prog_rdata(prog_rdata));
  bta_prog_mem i_mem (.hclk(hclk), .hresetn(hresetn), .prog(prog), .lat(lat),
    .prog_rvalid(prog_rvalid), .prog_rdata(prog_rdata));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] rev_ea(input logic [3:0] x);
    return 16'h1000 | {11'h000, x[0], x[1], x[2], x[3], 1'b0};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= bta_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic address_generator(input logic w, b, input bta_pkg::bta_amode_type am,
                     input logic [3:0] idx, input logic [15:0] ptr);
    agu_req <= '{valid:1'b1, write:w, byte_op:b, amode:am, ptr_idx:idx, ptr:ptr,
                 offset:16'($urandom()), mod_active:1'b1, mod_addr:16'($urandom())};
    @(posedge hclk);
    agu_req.valid <= 1'b0;
    @(posedge hclk);
    chk("agu valid", 32'h1, {31'h0, agu_rsp.valid});
    ea = agu_rsp.ea;
    pn = agu_rsp.ptr_new;
    br = agu_rsp.bitrev;
  endtask
  task automatic tbl(input logic w, h, b, ps, input logic [15:0] a);
    logic [23:0] wd, wx, lm;
    logic [15:0] ex, wv;
    logic [2:0]  st;
    int          n;
    wd = {a[7:0] ^ page, a[15:0] ^ 16'hC3A5};
    wv = 16'($urandom());
    ex = ps ? wd[15:0]
       : (!h ? (b ? (a[0] ? {8'h00, wd[15:8]} : {8'h00, wd[7:0]}) : wd[15:0])
       : ((b && a[0]) ? 16'h0000 : {8'h00, wd[23:16]}));
    st = h ? ((b && a[0]) ? 3'h0 : 3'h4) : (b ? (a[0] ? 3'h2 : 3'h1) : 3'h3);
    wx = h ? {wv[7:0], 16'h0000} : (b ? {8'h00, wv[7:0], wv[7:0]} : {8'h00, wv});
    lm = {{8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    while (tbl_ready !== 1'b1) @(posedge hclk);
    tbl_req <= '{valid:1'b1, write:w, high:h, byte_op:b, psv:ps, ea:a, wdata:wv};
    @(posedge hclk);
    tbl_req.valid <= 1'b0;
    @(posedge hclk);
    if (w && ps) begin
      chk("refused", 32'h1, {31'h0, tbl_rsp.refused});
      chk("window req", 32'h0, {31'h0, prog.req});
    end else begin
      chk("prog addr", {8'h00, page, a}, {8'h00, prog.addr});
      chk("cfg space", {31'h0, page[7]}, {31'h0, prog.cfg_space});
      chk("prog write", {31'h0, w}, {31'h0, prog.write});
      if (w) begin
        chk("strobe", {29'h0, st}, {29'h0, prog.wstrb});
        chk("write data", {8'h00, wx & lm}, {8'h00, prog.wdata & lm});
      end else begin
        n = 0;
        while (tbl_rsp.valid !== 1'b1 && n < 20) begin
          @(posedge hclk);
          n++;
        end
        chk("read valid", 32'h1, {31'h0, tbl_rsp.valid});
        chk("read data", {16'h0, ex}, {16'h0, tbl_rsp.data});
      end
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    repeat (6000) @(posedge hclk);
    num_errors++;
    results();
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, agu_req, tbl_req} = '0;
    hsize = 3'h2;
    lat = 3'h1;
    page = 8'h00;
    num_errors = 0;
    checked = 0;
    void'($urandom(18465));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, bta_pkg::ADDR_PIVOT, 0);
    chk("pivot reset", 32'h0, rd);
    ahb(0, bta_pkg::ADDR_MODE, 0);
    chk("mode reset", 32'h0F00, rd);
    ahb(1, 8'h10, 32'hFFFFFFFF);
    ahb(0, 8'h10, 0);
    chk("unmapped", 32'h0, rd);
    ahb(1, bta_pkg::ADDR_MODE, 32'h0300);
    ahb(1, bta_pkg::ADDR_PIVOT, 32'h8008);  // no pointer read follows at once
    ahb(0, bta_pkg::ADDR_PIVOT, 0);
    chk("pivot", 32'h8008, rd);
    p = 16'h1000;  // buffer base with its low bits clear
    for (k = 0; k < 16; k++) begin
      m = ($urandom() & 1) ? bta_pkg::AM_PRE_INC : bta_pkg::AM_POST_INC;
      address_generator(1, 0, m, 4'h3, (k == 0) ? (p | 16'h1) : p);
      chk("bitrev", 32'h1, {31'h0, br});
      chk("ptr new", {16'h0, rev_ea(4'(k + 1))}, {16'h0, pn});
      chk("rev ea", {16'h0, rev_ea((m == bta_pkg::AM_PRE_INC) ? 4'(k + 1) : 4'(k))},
          {16'h0, ea});
      p = pn;
    end
    ahb(0, bta_pkg::ADDR_STATUS, 0);
    chk("status", 32'h1, rd);
    for (k = 0; k < 4; k++) begin
      address_generator(k != 0, k == 1, (k == 2) ? bta_pkg::AM_INDIRECT : bta_pkg::AM_POST_INC,
          (k == 3) ? 4'h4 : 4'h3, 16'h2000);
      chk("no bitrev", 32'h0, {31'h0, br});
      if (k != 2) chk("normal ea", 32'h2000, {16'h0, ea});
    end
    ahb(1, bta_pkg::ADDR_PIVOT, 32'h0008);
    address_generator(1, 0, bta_pkg::AM_PRE_INC, 4'h3, 16'h2000);
    chk("rev off", 32'h0, {31'h0, br});
    ahb(1, bta_pkg::ADDR_PIVOT, 32'h8008);
    ahb(1, bta_pkg::ADDR_MODE, 32'h0F00);
    address_generator(1, 0, bta_pkg::AM_PRE_INC, 4'hF, 16'h2000);
    chk("select none", 32'h0, {31'h0, br});
    for (k = 0; k < 48; k++) begin
      if (k % 12 == 0) begin
        page = (k == 0) ? 8'h80 : 8'($urandom());
        ahb(1, bta_pkg::ADDR_PAGE, {24'h0, page});
        ahb(0, bta_pkg::ADDR_PAGE, 0);
        chk("page", {24'h0, page}, rd);
      end
      lat <= 3'($urandom_range(4, 1));
      if (k == 0) tbl(0, 1, 1, 0, 16'h0003);
      else if (k == 1) tbl(1, 0, 0, 1, 16'h0100);
      else tbl(1'($urandom()), 1'($urandom()), 1'($urandom()), 0, 16'($urandom()));
    end
    tbl(0, 1, 0, 1, 16'h0042);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    chk("ready reset", 32'h1, {31'h0, tbl_ready});
    ahb(0, bta_pkg::ADDR_PIVOT, 0);
    chk("pivot reset", 32'h0, rd);
    results();
  end
endmodule
`default_nettype wire
